// ==== core/sbg_defines.svh ====
// offsets, field positions, reset values and timing counts for the standby pin block
// assumes inclusion by bare name from the design file
`ifndef SBG_DEFINES_SVH
`define SBG_DEFINES_SVH
`define SBG_OFS_LEVELS 8'h08
`define SBG_OFS_SELECT 8'h13
`define SBG_OFS_SETTINGS 8'h14
`define SBG_LEVELS_RST 6'h3F
`define SBG_SET_RST 7'h44
`define SBG_SEL_RST 3'h0
`define SBG_BIT_OE 0
`define SBG_BIT_OTYPE 1
`define SBG_BIT_PU 2
`define SBG_BIT_LOCK 3
`define SBG_BIT_TYPE 4
`define SBG_BIT_POL 5
`define SBG_BIT_DEB 6
`define SBG_NUM_PINS 8
`define SBG_NUM_OUT 6
`define SBG_CLK_KHZ 200000
`define SBG_DEB_MS 15
`define SBG_DEB_CYC (`SBG_DEB_MS * `SBG_CLK_KHZ)
`endif

// ==== core/sbg_pkg.sv ====
// types shared by the standby pin block and its users
// assumes sbg_defines.svh on the include path
package sbg_pkg;
	// one register access, taken in a single cycle
	typedef struct packed {
		logic wr;
		logic rd;
		logic cfg_bank;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sbg_req_t;
	// per-pin settings slot, bit 7 reserved and not stored
	typedef struct packed {
		logic deb;
		logic pol;
		logic typ;
		logic lock;
		logic pu;
		logic otype;
		logic oe;
	} sbg_set_t;
endpackage

// ==== core/sbg_pin_port.sv ====
// settings slots, output levels, pin drive and debounced event detect for eight standby pins
// assumes one clock, register requests from same-domain logic, pin levels from outside
`timescale 1ns/1ps
`default_nettype none
`include "sbg_defines.svh"

// What this block does
// - A settings write lands only in the slot of the pin named by the pin index.
// - Settings bit 5 picks falling/low events at 0 and rising/high events at 1.
// - Settings bit 4 picks edge events at 0 and level events at 1.
// - A set lock freezes bits 2-0, the lock itself and the output level, and only power-up reset clears it.
// - Settings bit 2 turns the pin pull-up on at 1, its reset value.
// - Settings bit 1 picks open-drain at 0 and push-pull at 1.
// - Settings bit 0 enables the output driver, otherwise the pin floats, input sampling unaffected.
// - Output levels load 3Fh on power-up reset, and on software reset only for unlocked bits.
// - Output level bits 5-0 are driven on pins 5-0 while each output is enabled in push-pull; open-drain drives only a 0.
// - A write to an output level bit is ignored while its pin is locked.
// - Reading output levels returns the latched value, not the pins.
// - With debounce on, an input reaches the detector only after 15 ms without change.
// - Pin index bits 2-0 pick one of the eight pins.
// - Settings bits 0-3 exist only for the six output pins, bits 4-6 for all eight.
module sbg_pin_port #(
	parameter int unsigned DEB_CYC = `SBG_DEB_CYC
) (
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	input wire logic sw_rst_i,
	input wire sbg_pkg::sbg_req_t req_i,
	output logic [7:0] rdata_o,
	input wire logic [7:0] pin_lvl_i,
	output logic [5:0] pin_out_o,
	output logic [5:0] pin_oe_o,
	output logic [5:0] pin_pu_o,
	output logic [7:0] event_o
);
	import sbg_pkg::*;

	sbg_set_t set_q [8];
	logic [2:0] sel_q;
	logic [5:0] lvl_q;
	logic [7:0] sync1_q, sync2_q, flt_q, flt_prev_q;
	logic [7:0] lock_v;

	function automatic logic hit(input sbg_req_t r, input logic bank, input logic [7:0] ofs);
		hit = (r.cfg_bank == bank) && (r.addr == ofs);
	endfunction

	// pin index register, low three bits only
	always_ff @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			sel_q <= `SBG_SEL_RST;
		else if (ce_i)
		begin
			if (sw_rst_i)
				sel_q <= `SBG_SEL_RST;
			else if (req_i.wr && hit(req_i, 1'b1, `SBG_OFS_SELECT))
				sel_q <= req_i.wdata[2:0];
		end
	end

	// settings slots; locked fields survive software reset as well
	genvar g;
	generate
		for (g = 0; g < `SBG_NUM_PINS; g++)
		begin : g_pin
			localparam bit OUTP = (g < `SBG_NUM_OUT);
			assign lock_v[g] = set_q[g].lock;
			always_ff @(posedge core_clk_i or negedge rstn_i)
			begin
				if (!rstn_i)
					set_q[g] <= OUTP ? `SBG_SET_RST : (`SBG_SET_RST & 7'h70);
				else if (ce_i)
				begin
					if (sw_rst_i)
					begin
						set_q[g].deb <= 1'(`SBG_SET_RST >> `SBG_BIT_DEB);
						set_q[g].pol <= 1'b0;
						set_q[g].typ <= 1'b0;
						if (OUTP && !set_q[g].lock)
						begin
							set_q[g].pu <= 1'b1;
							set_q[g].otype <= 1'b0;
							set_q[g].oe <= 1'b0;
						end
					end
					else if (req_i.wr && hit(req_i, 1'b1, `SBG_OFS_SETTINGS) && sel_q == g)
					begin
						set_q[g].deb <= req_i.wdata[`SBG_BIT_DEB];
						set_q[g].pol <= req_i.wdata[`SBG_BIT_POL];
						set_q[g].typ <= req_i.wdata[`SBG_BIT_TYPE];
						if (OUTP && !set_q[g].lock)
						begin
							set_q[g].lock <= req_i.wdata[`SBG_BIT_LOCK];
							set_q[g].pu <= req_i.wdata[`SBG_BIT_PU];
							set_q[g].otype <= req_i.wdata[`SBG_BIT_OTYPE];
							set_q[g].oe <= req_i.wdata[`SBG_BIT_OE];
						end
					end
				end
			end
		end
	endgenerate

	// output levels, each bit guarded by its own lock
	always_ff @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			lvl_q <= `SBG_LEVELS_RST;
		else if (ce_i)
		begin
			for (int i = 0; i < `SBG_NUM_OUT; i++)
			begin
				if (!lock_v[i])
				begin
					if (sw_rst_i)
						lvl_q[i] <= 1'b1;
					else if (req_i.wr && hit(req_i, 1'b0, `SBG_OFS_LEVELS))
						lvl_q[i] <= req_i.wdata[i];
				end
			end
		end
	end

	// read data, one cycle after the strobe; unmapped reads give zero
	always_ff @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			rdata_o <= 8'h00;
		else if (ce_i && req_i.rd)
		begin
			if (hit(req_i, 1'b0, `SBG_OFS_LEVELS))
				rdata_o <= {2'b00, lvl_q};
			else if (hit(req_i, 1'b1, `SBG_OFS_SELECT))
				rdata_o <= {5'h00, sel_q};
			else if (hit(req_i, 1'b1, `SBG_OFS_SETTINGS))
				rdata_o <= {1'b0, set_q[sel_q]};
			else
				rdata_o <= 8'h00;
		end
	end

	// pad drive: open-drain only pulls low, pull-up follows its bit
	always_ff @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			pin_out_o <= 6'h00;
			pin_oe_o <= 6'h00;
			pin_pu_o <= 6'h3F;
		end
		else if (ce_i)
		begin
			for (int i = 0; i < `SBG_NUM_OUT; i++)
			begin
				pin_out_o[i] <= lvl_q[i];
				pin_oe_o[i] <= set_q[i].oe && (set_q[i].otype || !lvl_q[i]);
				pin_pu_o[i] <= set_q[i].pu;
			end
		end
	end

	// two-flop synchroniser for the pad levels
	// resets to the pulled-up idle level so release of reset makes no false rising edge
	always_ff @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			sync1_q <= 8'hFF;
			sync2_q <= 8'hFF;
		end
		else if (ce_i)
		begin
			sync1_q <= pin_lvl_i;
			sync2_q <= sync1_q;
		end
	end

	// debounce: counter restarts on any change, so a chattering pin never passes
	logic [21:0] deb_cnt_q [8];
	generate
		for (g = 0; g < `SBG_NUM_PINS; g++)
		begin : g_deb
			always_ff @(posedge core_clk_i or negedge rstn_i)
			begin
				if (!rstn_i)
				begin
					deb_cnt_q[g] <= 22'h000000;
					flt_q[g] <= 1'b1;
				end
				else if (ce_i)
				begin
					if (!set_q[g].deb || sync2_q[g] == flt_q[g])
					begin
						deb_cnt_q[g] <= 22'h000000;
						flt_q[g] <= sync2_q[g];
					end
					else if (deb_cnt_q[g] >= 22'(DEB_CYC - 1))
					begin
						deb_cnt_q[g] <= 22'h000000;
						flt_q[g] <= sync2_q[g];
					end
					else
						deb_cnt_q[g] <= deb_cnt_q[g] + 22'h000001;
				end
			end
		end
	endgenerate

	// event detect: level follows polarity, edge pulses on the active transition
	always_ff @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			flt_prev_q <= 8'hFF;
			event_o <= 8'h00;
		end
		else if (ce_i)
		begin
			flt_prev_q <= flt_q;
			for (int i = 0; i < `SBG_NUM_PINS; i++)
			begin
				if (set_q[i].typ)
					event_o[i] <= (flt_q[i] == set_q[i].pol);
				else
					event_o[i] <= (flt_q[i] != flt_prev_q[i]) && (flt_q[i] == set_q[i].pol);
			end
		end
	end

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rstn_i);

	// pin 2 is the one the bench locks, so these checks see real traffic
	chk_lock_holds_set: assert property (ce_i && set_q[2].lock |=> set_q[2].lock && $stable(set_q[2].oe))
		else $error("locked pin 2 changed");
	chk_locked_level_kept: assert property (ce_i && set_q[2].lock |=> $stable(lvl_q[2]))
		else $error("locked output level changed");
	chk_sel_routes_write: assert property (ce_i && !sw_rst_i && req_i.wr
		&& hit(req_i, 1'b1, `SBG_OFS_SETTINGS) && sel_q != 3'h2 |=> $stable(set_q[2].typ))
		else $error("settings write hit unselected slot");
	chk_swrst_unlocked: assert property (ce_i && sw_rst_i && !set_q[3].lock |=> lvl_q[3])
		else $error("software reset did not set level");
	chk_level_read: assert property (ce_i && req_i.rd && hit(req_i, 1'b0, `SBG_OFS_LEVELS)
		|=> rdata_o == {2'b00, $past(lvl_q)})
		else $error("level read mismatch");
	chk_input_only_bits: assert property (set_q[6].oe == 1'b0 && set_q[7].lock == 1'b0)
		else $error("input-only pin kept output settings");
	chk_drive_follows: assert property (ce_i ##1 ce_i |=> pin_oe_o[0] == ($past(set_q[0].oe)
		&& ($past(set_q[0].otype) || !$past(lvl_q[0]))))
		else $error("pin 0 drive wrong");
	chk_pu_follows: assert property (ce_i |=> pin_pu_o[4] == $past(set_q[4].pu))
		else $error("pull-up wrong");
	chk_deb_wait: assert property (ce_i && set_q[5].deb && sync2_q[5] != flt_q[5]
		&& deb_cnt_q[5] == 22'h000000 |=> flt_q[5] == $past(flt_q[5]) || DEB_CYC <= 1)
		else $error("debounce passed early");
	chk_level_event: assert property (ce_i && set_q[6].typ
		|=> event_o[6] == ($past(flt_q[6]) == $past(set_q[6].pol)))
		else $error("level event wrong");

	cov_lock_set: cover property (set_q[2].lock);
	cov_edge_event: cover property (event_o[6] && !set_q[6].typ);
	cov_deb_pass: cover property (set_q[6].deb && $changed(flt_q[6]));
endmodule
`default_nettype wire

// ==== verif/sbg_pin_peer.sv ====
// model of the outside parts on the eight standby pins
// assumes the pad outputs of sbg_pin_port and a bench that sets the far drivers
`timescale 1ns/1ps
`default_nettype none
module sbg_pin_peer (
	input wire logic core_clk_i,
	input wire logic [5:0] pin_out_i,
	input wire logic [5:0] pin_oe_i,
	input wire logic [5:0] pin_pu_i,
	input wire logic [7:0] ext_val_i,
	input wire logic [7:0] ext_en_i,
	output logic [7:0] pin_lvl_o
);
	logic [7:0] churn_q = 8'hA5;
	logic [7:0] oe8, pu8, out8;
	assign oe8 = {2'h0, pin_oe_i};
	assign pu8 = {2'h0, pin_pu_i};
	assign out8 = {2'h0, pin_out_i};
	// a floating line wanders every cycle, so a stale level is never trusted
	always_ff @(posedge core_clk_i)
		churn_q <= ~churn_q;
	// wire level: device drive, then far driver, then pull-up, else noise
	always_comb
	begin
		for (int i = 0; i < 8; i++)
		begin
			if (oe8[i])
				pin_lvl_o[i] = out8[i];
			else if (ext_en_i[i])
				pin_lvl_o[i] = ext_val_i[i];
			else if (pu8[i])
				pin_lvl_o[i] = 1'b1;
			else
				pin_lvl_o[i] = churn_q[i];
		end
	end
endmodule
`default_nettype wire

// ==== verif/standby_gpio_pin_config_data_out_test.sv ====
// self-checking bench for the standby pin settings and output levels
// assumes sbg_pkg compiled first and the pin peer model beside it
`timescale 1ns/1ps
`default_nettype none
module standby_gpio_pin_config_data_out_test;
	import sbg_pkg::*;
	logic core_clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic sw_rst_i = 1'b0;
	logic ce = 1'b1;
	sbg_req_t req = '0;
	logic [7:0] rdata, lvl, evt, v;
	logic [7:0] ext_val = 8'hFF;
	logic [5:0] pout, poe, ppu, el;
	logic [31:0] seed = 32'h10E77836;
	logic [6:0] es [8];
	int num_errors = 0;
	int checked = 0;
	int cyc = 0;
	sbg_pin_port #(.DEB_CYC(8)) dut_u (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .ce_i(ce),
		.sw_rst_i(sw_rst_i), .req_i(req), .rdata_o(rdata), .pin_lvl_i(lvl), .pin_out_o(pout),
		.pin_oe_o(poe), .pin_pu_o(ppu), .event_o(evt));
	sbg_pin_peer peer_u (.core_clk_i(core_clk_i), .pin_out_i(pout), .pin_oe_i(poe), .pin_pu_i(ppu),
		.ext_val_i(ext_val), .ext_en_i(8'hC0), .pin_lvl_o(lvl));
	// 200 MHz clock
	initial
	begin
		forever #2.5 core_clk_i = ~core_clk_i;
	end
	// hang guard, far above the several hundred cycles the run needs
	always @(posedge core_clk_i)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			num_errors++;
			summarize();
		end
	end
	task automatic summarize();
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// repeatable random source for slots and levels
	function automatic logic [31:0] xorshift(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		xorshift = t ^ (t << 5);
	endfunction
	// expected slots and levels after power-up reset, locks clear
	task automatic init_exp();
		for (int p = 0; p < 8; p++)
			es[p] = (p < 6) ? 7'h44 : 7'h40;
		el = 6'h3F;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("MISMATCH %0t got %h want %h", $time, got, exp);
		end
	endtask
	// one access, then an idle cycle so the strobe is never reassigned in one step
	task automatic acc(input logic w, input logic bank, input logic [7:0] a, input logic [7:0] d);
		req <= '{wr: w, rd: !w, cfg_bank: bank, addr: a, wdata: d};
		@(negedge core_clk_i);
		req <= '0;
		@(negedge core_clk_i);
	endtask
	task automatic rd(input logic bank, input logic [7:0] a, input logic [7:0] exp);
		acc(1'b0, bank, a, 8'h00);
		chk(rdata, exp);
	endtask
	// expected slot after a write: a set lock freezes bits 3-0
	task automatic wr_set(input logic [2:0] p, input logic [7:0] d);
		acc(1'b1, 1'b1, 8'h13, {5'h1F, p});
		acc(1'b1, 1'b1, 8'h14, d);
		if (!es[p][3])
			es[p][3:0] = d[3:0];
		es[p][6:4] = d[6:4];
		if (p > 5)
			es[p][3:0] = 4'h0;
	endtask
	task automatic wr_lvl(input logic [7:0] d);
		acc(1'b1, 1'b0, 8'h08, d);
		for (int i = 0; i < 6; i++)
			el[i] = es[i][3] ? el[i] : d[i];
	endtask
	task automatic check_all();
		logic [5:0] eoe, epu;
		repeat (3) @(negedge core_clk_i);
		for (int i = 0; i < 6; i++)
		begin
			eoe[i] = es[i][0] & (es[i][1] | ~el[i]);
			epu[i] = es[i][2];
		end
		chk({2'h0, pout}, {2'h0, el});
		chk({2'h0, poe}, {2'h0, eoe});
		chk({2'h0, ppu}, {2'h0, epu});
		rd(1'b0, 8'h08, {2'h0, el});
		for (int p = 0; p < 8; p++)
		begin
			acc(1'b1, 1'b1, 8'h13, p[7:0]);
			rd(1'b1, 8'h13, p[7:0]);
			rd(1'b1, 8'h14, {1'b0, es[p]});
		end
	endtask
	// edge and level events on input-only pin 6, driven by the far side
	task automatic evt_try(input logic [7:0] mode, input int hold);
		ext_val[6] <= ~mode[5];
		wr_set(3'h6, mode);
		repeat (30) @(negedge core_clk_i);
		chk({7'h0, evt[6]}, 8'h00);
		ext_val[6] <= mode[5];
		repeat (hold) @(negedge core_clk_i);
		chk({7'h0, evt[6]}, 8'h00);
		for (int t = 0; t < 20 && evt[6] !== 1'b1; t++)
			@(negedge core_clk_i);
		chk({7'h0, evt[6]}, 8'h01);
		repeat (3) @(negedge core_clk_i);
		chk({7'h0, evt[6]}, {7'h0, mode[4]});
	endtask
	initial
	begin
		repeat (4) @(negedge core_clk_i);
		rstn_i <= 1'b1;
		init_exp();
		check_all();
		rd(1'b0, 8'h0A, 8'h00);
		// random slots and levels, lock kept clear so all stays writable
		repeat (20)
		begin
			seed = xorshift(seed);
			v = seed[15:8];
			wr_set(v[2:0], seed[7:0] & 8'hF7);
			wr_lvl(seed[23:16]);
		end
		check_all();
		// lock pin 2 as push-pull output, then try to undo it
		wr_set(3'h2, 8'h0B);
		wr_set(3'h2, 8'h04);
		wr_lvl(8'h00);
		check_all();
		// clock enable low: a level write must leave everything as it was
		ce <= 1'b0;
		acc(1'b1, 1'b0, 8'h08, 8'h00);
		ce <= 1'b1;
		check_all();
		@(negedge core_clk_i);
		sw_rst_i <= 1'b1;
		@(negedge core_clk_i);
		sw_rst_i <= 1'b0;
		for (int p = 0; p < 8; p++)
		begin
			es[p][6:4] = 3'h4;
			es[p][3:0] = es[p][3] ? es[p][3:0] : ((p < 6) ? 4'h4 : 4'h0);
			if (p < 6 && !es[p][3])
				el[p] = 1'b1;
		end
		check_all();
		evt_try(8'h00, 1);
		evt_try(8'h20, 1);
		evt_try(8'h10, 1);
		evt_try(8'h30, 1);
		evt_try(8'h70, 6);
		// power-up reset in mid-run is the only thing that frees the lock on pin 2
		rstn_i <= 1'b0;
		repeat (2) @(negedge core_clk_i);
		rstn_i <= 1'b1;
		init_exp();
		check_all();
		summarize();
	end
endmodule
`default_nettype wire
